// file: common/ext_dma_cfg.svh
// Timing counts, widths and reset values for the external DMA request and grant logic.
`ifndef EXT_DMA_CFG_SVH
`define EXT_DMA_CFG_SVH

// Number of DMA channels in the controller; no figure is given, so this is a plain default.
`define DEFAULT_NUM_CH 8
// Width of a channel index; must cover the number of channels.
`define CH_IDX_W 3
// Least number of bus clock cycles for which the external grant stays low.
`define MIN_GRANT_HCLK 8
// Width of the grant hold counter.
`define GRANT_CNT_W 4
// Idle level of the active-low request and grant lines.
`define EXT_LINE_IDLE 1'b1

`endif

// file: common/ext_dma_pkg.sv
// Types shared by the external DMA request and grant logic.
`include "ext_dma_cfg.svh"

package ext_dma_pkg;

  // Index of a DMA channel.
  typedef logic [`CH_IDX_W-1:0] ch_idx_t;

  // Grant hold counter.
  typedef logic [`GRANT_CNT_W-1:0] grant_cnt_t;

  // Burst sequencer states.
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_BURST,
    ST_FLUSH
  } burst_state_e;

endpackage

// file: common/ext_req_if.sv
// Signals between the burst sequencer and the external request synchroniser.
`timescale 1ns/1ps
`default_nettype none

interface ext_req_if;
  logic hold;     // Freeze the synchroniser while the grant is low.
  logic flush;    // Reload the synchroniser with the idle level.
  logic req_seen; // Synchronised request, active high.

  // The sequencer side.
  modport ctrl (output hold, output flush, input req_seen);
  // The synchroniser side.
  modport sync (input hold, input flush, output req_seen);
endinterface

`default_nettype wire

// file: verilog/ext_req_sync.sv
// Two-stage synchroniser for the active-low external DMA request pin.
`timescale 1ns/1ps
`default_nettype none
`include "ext_dma_cfg.svh"

module ext_req_sync (
  input wire logic i_clk,      // Bus clock.
  input wire logic i_rst_n,    // Asynchronous reset, active low.
  input wire logic i_req_n,    // Raw request pin, active low.
  ext_req_if.sync  req         // Control and result towards the sequencer.
);

  logic meta_q;
  logic sync_q;

  // Both stages rest at the idle level; hold freezes them, flush restarts them from idle.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      meta_q <= `EXT_LINE_IDLE;
      sync_q <= `EXT_LINE_IDLE;
    end else if (req.flush) begin
      meta_q <= `EXT_LINE_IDLE;
      sync_q <= `EXT_LINE_IDLE;
    end else if (!req.hold) begin
      meta_q <= i_req_n;
      sync_q <= meta_q;
    end
  end

  // A low synchronised level is a pending request.
  assign req.req_seen = ~sync_q;

endmodule

`default_nettype wire

// file: verilog/ext_dma_request_grant.sv
// Burst arbiter and external request and grant handshake of the DMA controller.
`timescale 1ns/1ps
`default_nettype none
`include "ext_dma_cfg.svh"

module ext_dma_request_grant #(
  parameter int NUM_CH = `DEFAULT_NUM_CH,
  parameter int MIN_GRANT_CYC = `MIN_GRANT_HCLK
) (
  input wire logic I_MCLK,                     // Bus clock, 10 MHz.
  input wire logic I_RST_N,                    // Asynchronous reset, active low.
  input wire logic I_EXT_REQ_N,                // External request pin, active low.
  input wire logic [NUM_CH-1:0] I_CH_SRC_EXT,  // Channel request source select is the external line.
  input wire logic [NUM_CH-1:0] I_CH_REQ_EN,   // Channel request enable.
  input wire logic [NUM_CH-1:0] I_CH_ACTIVE_EN, // Channel active enable.
  input wire logic [NUM_CH-1:0] I_CH_REQ,      // Internal request per channel, same clock.
  input wire logic I_BURST_DONE,               // Datapath pulse: current burst has completed.
  output logic O_EXT_GRANT_N,                  // External grant pin, active low.
  output logic O_BURST_START,                  // One-cycle pulse when a burst starts.
  output ext_dma_pkg::ch_idx_t O_BURST_CH,     // Channel of the current burst.
  output logic O_BURST_BUSY,                   // High while a burst is running.
  output logic O_EXT_BURST                     // High while the burst serves the external line.
);
  import ext_dma_pkg::*;

  // Carries hold and flush to the synchroniser and the synchronised request back.
  ext_req_if req_if ();

  // Registered state of the sequencer and of every output.
  burst_state_e state_q;
  logic grant_n_q;
  logic start_q;
  ch_idx_t ch_q;
  logic busy_q;
  logic ext_burst_q;
  logic ext_low_q;
  logic done_seen_q;
  grant_cnt_t cnt_q;

  // Combinational arbitration signals.
  logic [NUM_CH-1:0] req_vec;
  logic [NUM_CH-1:0] elig_vec;
  logic other_req;
  logic pick_v;
  ch_idx_t pick_ch;
  logic pick_grant;
  logic burst_end;

  // Last count of the minimum grant span; the counter is zero in the first grant cycle.
  localparam grant_cnt_t MIN_GRANT_LAST = grant_cnt_t'(MIN_GRANT_CYC - 1);

  // Picks the lowest-numbered requesting channel, which has the highest priority.
  // The scan runs from the top down so that the last hit, the lowest index, is kept.
  function automatic logic [`CH_IDX_W:0] arbitrate(input logic [NUM_CH-1:0] vec);
    logic [`CH_IDX_W:0] res;
    res = '0;
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (vec[i]) begin
        res = {1'b1, ch_idx_t'(i)};
      end
    end
    return res;
  endfunction

  // The raw pin is asynchronous, so only the second stage of this synchroniser feeds the arbiter.
  // request synchroniser
  ext_req_sync u_sync (
    .i_clk   (I_MCLK),
    .i_rst_n (I_RST_N),
    .i_req_n (I_EXT_REQ_N),
    .req     (req_if.sync)
  );

  // The grant is only issued with the request seen, so the frozen stages keep showing it.
  // freeze while granted
  assign req_if.hold = ~grant_n_q;
  // Reloading idle after an external burst drops the level frozen in the stages.
  // A request that the peripheral released in time then never yields a second burst.
  // restart sampling after burst
  assign req_if.flush = (state_q == ST_FLUSH) && ext_burst_q;

  // Per-channel request: enabled, active, and asserted on its selected source.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_req
      assign req_vec[g] = I_CH_REQ_EN[g] & I_CH_ACTIVE_EN[g] &
                          (I_CH_SRC_EXT[g] ? req_if.req_seen : I_CH_REQ[g]);
    end
  endgenerate

  // The mask lasts only until the next burst starts, so a lone external request is never starved.
  // external drops priority
  assign other_req = |(req_vec & ~I_CH_SRC_EXT);
  assign elig_vec = (ext_low_q && other_req) ? (req_vec & ~I_CH_SRC_EXT) : req_vec;

  assign {pick_v, pick_ch} = arbitrate(elig_vec);

  // A burst can also start for an internal channel; then the grant simply stays high.
  // grant qualification
  assign pick_grant = I_CH_SRC_EXT[pick_ch] & I_CH_REQ_EN[pick_ch] &
                      I_CH_ACTIVE_EN[pick_ch] & req_if.req_seen;

  // An early completion is remembered, so a one-byte burst still keeps the grant low for the full span.
  // This gives the peripheral time to see the grant and release its request.
  // minimum grant time
  assign burst_end = (done_seen_q || I_BURST_DONE) &&
                     (grant_n_q || (cnt_q >= MIN_GRANT_LAST));

  // Burst sequencer: idle, burst running, one-cycle flush of the request path.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      state_q <= ST_IDLE;
    end else begin
      unique case (state_q)
        ST_IDLE: begin
          if (pick_v) begin
            state_q <= ST_BURST;
          end
        end
        ST_BURST: begin
          if (burst_end) begin
            state_q <= ST_FLUSH;
          end
        end
        ST_FLUSH: begin
          state_q <= ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      grant_n_q <= `EXT_LINE_IDLE;
    end else if (state_q == ST_IDLE && pick_v) begin
      grant_n_q <= ~pick_grant;
    end else if (state_q == ST_BURST && burst_end) begin
      grant_n_q <= `EXT_LINE_IDLE;
    end
  end

  // Counts burst-state cycles from zero; saturates at MIN_GRANT_LAST, one below the minimum.
  // Saturating keeps the counter from wrapping during long bursts.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      cnt_q <= '0;
    end else if (state_q != ST_BURST) begin
      cnt_q <= '0;
    end else if (cnt_q < MIN_GRANT_LAST) begin
      cnt_q <= cnt_q + 1'b1;
    end
  end

  // Remembers a completion that arrives before the minimum grant time ends.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      done_seen_q <= 1'b0;
    end else if (state_q != ST_BURST) begin
      done_seen_q <= 1'b0;
    end else if (I_BURST_DONE) begin
      done_seen_q <= 1'b1;
    end
  end

  // Burst start pulse, channel, busy and external-burst flags.
  // The external flag stays up through the flush cycle so that the flush knows whose burst it was.
  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      start_q <= 1'b0;
      ch_q <= '0;
      busy_q <= 1'b0;
      ext_burst_q <= 1'b0;
    end else begin
      start_q <= (state_q == ST_IDLE) && pick_v;
      if (state_q == ST_IDLE && pick_v) begin
        ch_q <= pick_ch;
        busy_q <= 1'b1;
        ext_burst_q <= I_CH_SRC_EXT[pick_ch];
      end else if (state_q == ST_BURST && burst_end) begin
        busy_q <= 1'b0;
      end else if (state_q == ST_FLUSH) begin
        ext_burst_q <= 1'b0;
      end
    end
  end

  always_ff @(posedge I_MCLK or negedge I_RST_N) begin
    if (!I_RST_N) begin
      ext_low_q <= 1'b0;
    end else if (state_q == ST_BURST && burst_end && ext_burst_q) begin
      ext_low_q <= 1'b1;
    end else if (state_q == ST_IDLE && pick_v) begin
      ext_low_q <= 1'b0;
    end
  end

  assign O_EXT_GRANT_N = grant_n_q;
  assign O_BURST_START = start_q;
  assign O_BURST_CH = ch_q;
  assign O_BURST_BUSY = busy_q;
  assign O_EXT_BURST = ext_burst_q;

endmodule

`default_nettype wire

// file: tb/ext_dma_request_grant_assertions.sv
// Assertions on the request and grant ports of the burst arbiter.
`timescale 1ns/1ps
`default_nettype none
module ext_dma_request_grant_assertions #(
  parameter int NUM_CH = 8,
  parameter int MIN_GRANT_CYC = 8
) (
  input wire logic I_MCLK, // Clock.
  input wire logic I_RST_N, // Reset.
  input wire logic I_EXT_REQ_N, // Request pin.
  input wire logic [NUM_CH-1:0] I_CH_SRC_EXT, // Source select.
  input wire logic [NUM_CH-1:0] I_CH_REQ_EN, // Request enable.
  input wire logic [NUM_CH-1:0] I_CH_ACTIVE_EN, // Active enable.
  input wire logic O_EXT_GRANT_N, // Grant pin.
  input wire logic O_BURST_START, // Start pulse.
  input wire ext_dma_pkg::ch_idx_t O_BURST_CH, // Channel.
  input wire logic O_BURST_BUSY, // Busy.
  input wire logic O_EXT_BURST // External burst.
);
  import ext_dma_pkg::*;
  logic [NUM_CH-1:0] elig_q;
  // Channels that could earn the grant at the last edge.
  always_ff @(posedge I_MCLK) elig_q <= I_CH_SRC_EXT & I_CH_REQ_EN & I_CH_ACTIVE_EN;
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (!I_RST_N);
  // The grant opens a burst and then holds for the minimum span.
  sequence s_fall; $fell(O_EXT_GRANT_N); endsequence
  sequence s_hold; !O_EXT_GRANT_N [*8]; endsequence
  grant_min_a: assert property (s_fall |-> s_hold) else $error("grant short");
  grant_start_a: assert property (s_fall |-> O_BURST_START && O_EXT_BURST) else $error("grant off start");
  grant_cond_a: assert property (s_fall |-> elig_q[O_BURST_CH]) else $error("grant unqualified");
  req_sync_a: assert property (s_fall |-> !$past(I_EXT_REQ_N, 3)) else $error("grant too early");
  grant_busy_a: assert property (!O_EXT_GRANT_N |-> O_BURST_BUSY) else $error("grant while idle");
  start_once_a: assert property (O_BURST_START |=> !O_BURST_START) else $error("start too long");
  no_rerun_a: assert property ($rose(O_EXT_GRANT_N) |-> !O_BURST_BUSY ##1 !O_BURST_START) else $error("rerun");
  reset_idle_a: assert property ($rose(I_RST_N) |-> O_EXT_GRANT_N && !O_BURST_BUSY) else $error("not idle");
endmodule
`default_nettype wire

// file: tb/ext_periph_model.sv
// Peripheral model that drives the external request pin.
`timescale 1ns/1ps
`default_nettype none
module ext_periph_model (
  input wire logic i_clk, // Clock.
  input wire logic i_rst_n, // Reset.
  input wire logic i_go, // Raise request.
  input wire logic i_grant_n, // Grant pin.
  input wire logic [3:0] i_hold, // Grant cycles before release.
  output logic o_req_n // Request pin.
);
  logic [3:0] cnt_q;
  // The request goes high after i_hold + 1 grant cycles, and never later than the eighth one.
  // A hold of zero frees the line on the first grant cycle, before any read or write completes.
  // request held until served.
  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_req_n <= 1'b1;
      cnt_q <= 4'h0;
    end else if (i_go) begin
      o_req_n <= 1'b0;
      cnt_q <= 4'h0;
    end else if (!o_req_n && !i_grant_n) begin
      cnt_q <= cnt_q + 4'h1;
      o_req_n <= (cnt_q == i_hold) || (cnt_q == 4'h7);
    end
  end
endmodule
`default_nettype wire

// file: tb/test_ext_dma_request_grant.sv
// Self-checking bench for the external DMA request and grant logic.
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin compares++; if ((g) !== (e)) begin miscompares++; \
  $display("MISMATCH at %0t: got %0h want %0h", $time, g, e); end end
module test_ext_dma_request_grant;
  import ext_dma_pkg::*;
  logic clk, rst_n, go, done, req_n, gnt_n, start, busy, extb, seen;
  logic [3:0] hold;
  logic [7:0] src, ren, channel_active_enable, ireq;
  logic [6:0] r;
  ch_idx_t ch;
  int compares, miscompares, len;
  // Rows: go, source, enables, internal request, expected start and grant.
  logic [6:0] rows [5] = '{7'h7b, 7'h68, 7'h70, 7'h1e, 7'h38};
  ext_dma_request_grant i_dut (.I_MCLK(clk), .I_RST_N(rst_n), .I_EXT_REQ_N(req_n), .I_CH_SRC_EXT(src),
    .I_CH_REQ_EN(ren), .I_CH_ACTIVE_EN(channel_active_enable), .I_CH_REQ(ireq), .I_BURST_DONE(done), .O_EXT_GRANT_N(gnt_n),
    .O_BURST_START(start), .O_BURST_CH(ch), .O_BURST_BUSY(busy), .O_EXT_BURST(extb));
  ext_periph_model i_periph (.i_clk(clk), .i_rst_n(rst_n), .i_go(go), .i_grant_n(gnt_n), .i_hold(hold),
    .o_req_n(req_n));
  // Free-running bus clock.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Watchdog that cuts a hang short.
  initial begin
    repeat (3000) @(posedge clk);
    miscompares++;
    results();
  end
  task automatic results();
    $display("compares %0d miscompares %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic do_reset();
    @(posedge clk) rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask
  task automatic wait_start();
    seen = 1'b0;
    for (int k = 0; k < 12 && !seen; k++) begin
      @(negedge clk);
      seen = (start === 1'b1);
    end
  endtask
  task automatic end_burst(input int dly);
    len = 0;
    for (int k = 0; k < 40 && busy === 1'b1; k++) begin
      len += (gnt_n === 1'b0);
      @(posedge clk) done <= (k == dly);
      @(negedge clk);
    end
  endtask
  // Reset, the table of ordinary cases, then the awkward cases.
  initial begin
    {rst_n, go, done, hold, src, ren, channel_active_enable, ireq} = '0;
    do_reset();
    @(negedge clk);
    `CHK({gnt_n, busy, start, extb}, 4'h8)
    for (int i = 0; i < 5; i++) begin
      r = rows[i];
      do_reset();
      {src, ren, channel_active_enable, ireq} <= {8'(r[5]) << 2, 8'(r[4]) << 2, 8'(r[3]) << 2, 8'(r[2]) << 2};
      go <= r[6];
      @(posedge clk) go <= 1'b0;
      wait_start();
      `CHK(seen, r[1])
      if (seen) begin
        `CHK({ch, gnt_n, extb, busy}, {3'h2, ~r[0], r[5], 1'b1})
      end
    end
    for (int j = 0; j < 2; j++) begin
      do_reset();
      {src, ren, channel_active_enable} <= {3{8'h04}};
      go <= 1'b1;
      @(posedge clk) go <= 1'b0;
      wait_start();
      fork
        end_burst(j * 10);
        begin
          repeat (3) @(posedge clk);
          go <= 1'b1;
          @(posedge clk) go <= 1'b0;
        end
      join
      `CHK(len, j * 4 + 8)
      wait_start();
      `CHK(seen, 1'b0)
    end
    do_reset();
    {src, ren, channel_active_enable, hold} <= {8'h01, 8'h03, 8'h03, 4'h3};
    go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    wait_start();
    `CHK(ch, 3'h0)
    end_burst(0);
    // A fresh external request and an internal one reach the arbiter at the same edge.
    @(posedge clk) go <= 1'b1;
    @(posedge clk) go <= 1'b0;
    repeat (2) @(posedge clk);
    ireq <= 8'h02;
    wait_start();
    `CHK({ch, gnt_n}, 4'h3)
    @(posedge clk) ireq <= 8'h00;
    end_burst(0);
    wait_start();
    `CHK({ch, gnt_n}, 4'h0)
    results();
  end
endmodule
bind ext_dma_request_grant ext_dma_request_grant_assertions #(.NUM_CH(NUM_CH), .MIN_GRANT_CYC(MIN_GRANT_CYC))
  i_chk (.I_MCLK, .I_RST_N, .I_EXT_REQ_N, .I_CH_SRC_EXT, .I_CH_REQ_EN, .I_CH_ACTIVE_EN, .O_EXT_GRANT_N,
  .O_BURST_START, .O_BURST_CH, .O_BURST_BUSY, .O_EXT_BURST);
`default_nettype wire
